// ---- rcs_consts.svh ----
// Constants of the reset cause and soft reset block.
// Assumes inclusion by the monitor, the top module and the bench only.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define RCS_ADDR_W           8
`define RCS_OFS_CAUSE        8'h00
`define RCS_OFS_TRIGGER      8'h04
`define RCS_OFS_KEY          8'h08
`define RCS_OFS_IRQ_STAT     8'h0C
`define RCS_OFS_IRQ_MASK     8'h10
`define RCS_OFS_LOCK_STAT    8'h14

// ------------------------------------------------------------
// Cause register fields
// ------------------------------------------------------------
`define RCS_BIT_HIGH_VOLTAGE_RESET_FLAG         29
`define RCS_BIT_CFG          9
`define RCS_BIT_VREG         8
`define RCS_BIT_PIN          7
`define RCS_BIT_SW           6
`define RCS_BIT_WDT          4
`define RCS_BIT_SLEEP        3
`define RCS_BIT_IDLE         2
`define RCS_BIT_BOR          1
`define RCS_BIT_POR          0
`define RCS_CAUSE_IMPL       32'h2000_03DF
`define RCS_CAUSE_POR_VAL    32'h0000_0003
`define RCS_IRQ_IMPL         32'h2000_02DF
`define RCS_TRIG_BIT         0

// ------------------------------------------------------------
// Unlock keys and soft reset timing
// ------------------------------------------------------------
`define RCS_KEY1             32'h1ACC_E55A
`define RCS_KEY2             32'h0B5E_2C7D
`define RCS_CLK_PERIOD_NS    100
`define RCS_SOFT_RESET_TRIGGER_BIT_TIME_NS    1600
`define RCS_SOFT_RESET_TRIGGER_BIT_CYCLES     ((`RCS_SOFT_RESET_TRIGGER_BIT_TIME_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS)

`endif

// ---- rcs_monitor.sv ----
// Port checker for the reset cause and soft reset block.
// Assumes it is bound into rcs_top; one clock domain.
`timescale 1ns/100ps
`include "rcs_consts.svh"
module rcs_monitor (
   input wire logic        CORE_CLK_I,     // Clock
   input wire logic        RESET_N_I,      // Reset
   input wire logic        CE_I,           // Enable
   input wire logic        PSEL_I,         // Select
   input wire logic        PENABLE_I,      // Access
   input wire logic        PWRITE_I,       // Write
   input wire logic [7:0]  PADDR_I,        // Address
   input wire logic [31:0] PWDATA_I,       // Wdata
   input wire logic [31:0] PRDATA_O,       // Rdata
   input wire logic        PREADY_O,       // Ready
   input wire logic        IRQ_O,          // Irq
   input wire logic        SOFT_RESET_O,   // Soft reset
   input wire logic        REG_SLEEP_EN_O, // Regulator
   input wire logic        UNLOCKED_O      // Unlocked
);
   logic       wr;   // Write access edge
   logic       t4;   // Trigger write
   logic       k2_q; // Second key seen
   logic [4:0] hi_q; // Pulse length
   // ----
   // Helper logic
   // ----
   assign wr = PSEL_I & PENABLE_I & PWRITE_I & CE_I;
   assign t4 = wr && PADDR_I == 8'h04;
   // Key tracking and pulse counting
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         k2_q <= 1'b0;
         hi_q <= 5'h00;
      end else begin
         k2_q <= wr && PADDR_I == 8'h08 && PWDATA_I == `RCS_KEY2;
         hi_q <= SOFT_RESET_O ? hi_q + 5'h01 : 5'h00;
      end
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   property p_unlock; $rose(UNLOCKED_O) |-> k2_q; endproperty
   a_unlock: assert property (p_unlock) else $error("unlock without key");
   property p_start; t4 && PWDATA_I[0] && UNLOCKED_O && !SOFT_RESET_O |=> SOFT_RESET_O; endproperty
   a_start: assert property (p_start) else $error("soft reset not started");
   property p_nostart; t4 && !(PWDATA_I[0] && UNLOCKED_O) && !SOFT_RESET_O |=> !SOFT_RESET_O; endproperty
   a_nostart: assert property (p_nostart) else $error("soft reset wrongly started");
   property p_relock; t4 |=> !UNLOCKED_O; endproperty
   a_relock: assert property (p_relock) else $error("no relock");
   property p_pulse; $fell(SOFT_RESET_O) |-> hi_q == 5'd16; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse length wrong");
   property p_sleep; wr && PADDR_I == 8'h00 |=> REG_SLEEP_EN_O == $past(PWDATA_I[8]); endproperty
   a_sleep: assert property (p_sleep) else $error("regulator bit wrong");
   property p_rsv; PREADY_O && !PWRITE_I && PADDR_I == 8'h00 |-> (PRDATA_O & ~`RCS_CAUSE_IMPL) == 0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_trig; PREADY_O && !PWRITE_I && PADDR_I == 8'h04 |-> PRDATA_O == 32'h0; endproperty
   a_trig: assert property (p_trig) else $error("trigger reads nonzero");
   property p_rst; $rose(RESET_N_I) |-> !SOFT_RESET_O && !UNLOCKED_O && !REG_SLEEP_EN_O && !IRQ_O; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind rcs_top rcs_monitor rcs_monitor_inst (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .IRQ_O(IRQ_O), .SOFT_RESET_O(SOFT_RESET_O),
   .REG_SLEEP_EN_O(REG_SLEEP_EN_O), .UNLOCKED_O(UNLOCKED_O));

// ---- rcs_pkg.sv ----
// Types of the reset cause and soft reset block.
// Assumes rcs_consts.svh is on the include path.
package rcs_pkg;

   // ---------------------------------------------------------
   // Event carrier and state machine codes
   // ---------------------------------------------------------
   typedef struct packed {
      logic hv;      // High voltage detect reset
      logic cfg;     // Configuration mismatch reset
      logic pin;     // Master clear pin reset
      logic wdt;     // Watchdog timeout
      logic bor;     // Brown-out reset
      logic slp;     // Wake from sleep
      logic idl;     // Wake from idle
   } rcs_evt_t;

   typedef enum logic [2:0] {
      LK_LOCKED = 3'b001,
      LK_KEY1   = 3'b010,
      LK_OPEN   = 3'b100
   } rcs_lock_t;

   typedef enum logic [1:0] {
      RS_IDLE = 2'b01,
      RS_BUSY = 2'b10
   } rcs_rst_t;

   // ---------------------------------------------------------
   // Whole state of the top module
   // ---------------------------------------------------------
   typedef struct packed {
      rcs_evt_t    s1;
      rcs_evt_t    s2;
      rcs_evt_t    s3;
      rcs_evt_t    filt;
      logic [31:0] cause;
      logic [31:0] irq_stat;
      logic [31:0] irq_mask;
      logic [31:0] prdata;
      logic        slverr;
      rcs_lock_t   lock;
      rcs_rst_t    rst;
      logic [7:0]  cnt;
   } rcs_state_t;

endpackage

// ---- rcs_top.sv ----
// Reset cause flags, soft reset trigger with unlock, APB slave.
// Assumes event inputs are asynchronous levels, one clock domain,
// and RESET_N_I is the power-on reset of the block.
//
// Function
// - Bit 29 of the cause register is set on a high voltage detect reset.
// - Bit 9 is set by hardware on a configuration mismatch reset and is read/write.
// - Bit 8 keeps the regulator on in sleep when one, standby tracking when zero, reset zero.
// - Bit 7 is set by hardware on a master clear pin reset.
// - Bit 6 is set by hardware once a software reset has been carried out.
// - Bit 4 is set by hardware on a watchdog timeout.
// - Bit 3 is set by hardware on wake from sleep.
// - Bit 2 is set by hardware on wake from idle.
// - Bit 1 is set on brown-out and is one after power-on.
// - Bit 0 is set on power-on and is one after power-on.
// - Cause bits 31-30, 28-10 and 5 read as zero.
// - Writing one to trigger bit 0 starts a software reset, writing zero starts none; any trigger write relocks the block.
// - The trigger write is accepted only while the block is unlocked.
// - Trigger bits 31-1 read as zero.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps

`include "rcs_consts.svh"

module rcs_top
   import rcs_pkg::*;
(
   input  wire logic        CORE_CLK_I,     // Core clock, 10 MHz
   input  wire logic        RESET_N_I,      // Power-on reset, async
   input  wire logic        CE_I,           // Clock enable
   input  wire logic        PSEL_I,         // APB select
   input  wire logic        PENABLE_I,      // APB enable
   input  wire logic        PWRITE_I,       // APB direction
   input  wire logic [7:0]  PADDR_I,        // APB byte address
   input  wire logic [31:0] PWDATA_I,       // APB write data
   input  wire rcs_evt_t    EVENTS_I,       // Async reset cause events
   output logic      [31:0] PRDATA_O,       // APB read data
   output logic             PREADY_O,       // APB ready
   output logic             PSLVERR_O,      // APB error
   output logic             IRQ_O,          // Level interrupt
   output logic             SOFT_RESET_O,   // Soft reset request
   output logic             REG_SLEEP_EN_O, // Regulator on in sleep
   output logic             UNLOCKED_O      // Unlock state
);

   // ---------------------------------------------------------
   // State and constants
   // ---------------------------------------------------------
   localparam logic [7:0] SOFT_RESET_TRIGGER_BIT_CNT = 8'(`RCS_SOFT_RESET_TRIGGER_BIT_CYCLES - 1);

   localparam rcs_state_t RESET_STATE = '{
      s1:       '0,
      s2:       '0,
      s3:       '0,
      filt:     '0,
      cause:    `RCS_CAUSE_POR_VAL,
      irq_stat: 32'h0000_0000,
      irq_mask: 32'h0000_0000,
      prdata:   32'h0000_0000,
      slverr:   1'b0,
      lock:     LK_LOCKED,
      rst:      RS_IDLE,
      cnt:      8'h00
   };

   rcs_state_t  r_reg;
   rcs_state_t  r_next;
   rcs_evt_t    rise;
   logic [31:0] set_vec;
   logic [31:0] rd_data;
   logic        rd_err;
   logic        setup;
   logic        wr;
   logic        sw_done;

   // ---------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------
   assign setup = PSEL_I & ~PENABLE_I;
   assign wr    = PSEL_I & PENABLE_I & PWRITE_I;

   // Rising edges of settled event levels
   assign rise = r_reg.s2 & r_reg.s3 & ~r_reg.filt;

   // Soft reset finished this cycle
   assign sw_done = (r_reg.rst == RS_BUSY) && (r_reg.cnt == 8'h00);

   // Event bits in cause layout
   always_comb begin
      set_vec = 32'h0000_0000;
      set_vec[`RCS_BIT_HIGH_VOLTAGE_RESET_FLAG]  = rise.hv;
      set_vec[`RCS_BIT_CFG]   = rise.cfg;
      set_vec[`RCS_BIT_PIN]   = rise.pin;
      set_vec[`RCS_BIT_SW]    = sw_done;
      set_vec[`RCS_BIT_WDT]   = rise.wdt;
      set_vec[`RCS_BIT_SLEEP] = rise.slp;
      set_vec[`RCS_BIT_IDLE]  = rise.idl;
      set_vec[`RCS_BIT_BOR]   = rise.bor;
   end

   // Read data mux, unimplemented bits zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (PADDR_I)
         `RCS_OFS_CAUSE:     rd_data = r_reg.cause & `RCS_CAUSE_IMPL;
         `RCS_OFS_TRIGGER:   rd_data = 32'h0000_0000;
         `RCS_OFS_KEY:       rd_data = 32'h0000_0000;
         `RCS_OFS_IRQ_STAT:  rd_data = r_reg.irq_stat;
         `RCS_OFS_IRQ_MASK:  rd_data = r_reg.irq_mask;
         `RCS_OFS_LOCK_STAT: rd_data = {30'h0, r_reg.rst == RS_BUSY, r_reg.lock == LK_OPEN};
         default:            rd_err  = 1'b1;
      endcase
   end

   // ---------------------------------------------------------
   // Next state
   // ---------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      if (CE_I) begin
         // Three-flop synchroniser, change taken when stages 2 and 3 agree
         r_next.s1 = EVENTS_I;
         r_next.s2 = r_reg.s1;
         r_next.s3 = r_reg.s2;
         for (int i = 0; i < $bits(rcs_evt_t); i++) begin
            if (r_reg.s2[i] == r_reg.s3[i]) begin
               r_next.filt[i] = r_reg.s3[i];
            end
         end

         // Read data and error captured in setup phase
         if (setup) begin
            r_next.prdata = rd_data;
            r_next.slverr = rd_err;
         end

         // Cause flags: written value kept, hardware set wins
         if (wr && PADDR_I == `RCS_OFS_CAUSE) begin
            r_next.cause = PWDATA_I & `RCS_CAUSE_IMPL;
         end
         r_next.cause = r_next.cause | set_vec;

         // Interrupt status, write one to clear, set wins
         if (wr && PADDR_I == `RCS_OFS_IRQ_STAT) begin
            r_next.irq_stat = r_reg.irq_stat & ~PWDATA_I;
         end
         r_next.irq_stat = r_next.irq_stat | (set_vec & `RCS_IRQ_IMPL);
         if (wr && PADDR_I == `RCS_OFS_IRQ_MASK) begin
            r_next.irq_mask = PWDATA_I & `RCS_IRQ_IMPL;
         end

         // Unlock key sequence
         case (r_reg.lock)
            LK_LOCKED: begin
               if (wr && PADDR_I == `RCS_OFS_KEY && PWDATA_I == `RCS_KEY1) begin
                  r_next.lock = LK_KEY1;
               end
            end
            LK_KEY1: begin
               if (wr) begin
                  if (PADDR_I == `RCS_OFS_KEY && PWDATA_I == `RCS_KEY2) begin
                     r_next.lock = LK_OPEN;
                  end else if (!(PADDR_I == `RCS_OFS_KEY && PWDATA_I == `RCS_KEY1)) begin
                     r_next.lock = LK_LOCKED;
                  end
               end
            end
            LK_OPEN: begin
               if (wr && PADDR_I == `RCS_OFS_TRIGGER) begin
                  r_next.lock = LK_LOCKED;
               end
            end
            default: r_next.lock = LK_LOCKED;
         endcase

         // Soft reset sequencer
         case (r_reg.rst)
            RS_IDLE: begin
               if (wr && PADDR_I == `RCS_OFS_TRIGGER && r_reg.lock == LK_OPEN
                   && PWDATA_I[`RCS_TRIG_BIT]) begin
                  r_next.rst = RS_BUSY;
                  r_next.cnt = SOFT_RESET_TRIGGER_BIT_CNT;
               end
            end
            RS_BUSY: begin
               if (r_reg.cnt == 8'h00) begin
                  r_next.rst = RS_IDLE;
               end else begin
                  r_next.cnt = r_reg.cnt - 8'h01;
               end
            end
            default: r_next.rst = RS_IDLE;
         endcase
      end
   end

   // State register, power-on values under reset
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         r_reg <= RESET_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   assign PREADY_O       = PSEL_I & PENABLE_I;
   assign PRDATA_O       = r_reg.prdata;
   assign PSLVERR_O      = PREADY_O & r_reg.slverr;
   assign IRQ_O          = |(r_reg.irq_stat & r_reg.irq_mask);
   assign SOFT_RESET_O   = (r_reg.rst == RS_BUSY);
   assign REG_SLEEP_EN_O = r_reg.cause[`RCS_BIT_VREG];
   assign UNLOCKED_O     = (r_reg.lock == LK_OPEN);

endmodule

// ---- test_reset_cause_and_soft_reset.sv ----
// Self-checking bench for rcs_top.
// Assumes rcs_pkg and rcs_monitor compiled first.
`timescale 1ns/100ps
`include "rcs_consts.svh"
module test_reset_cause_and_soft_reset
   import rcs_pkg::*;
;
   logic        clk, rst_n, ce, psel, pen, pwr, pready, pslverr, irq, srst, slp, unl, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, m;
   logic [6:0]  p;
   rcs_evt_t    ev;
   int          err_count, checked, n;
   rcs_top rcs_top_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .EVENTS_I(ev), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .SOFT_RESET_O(srst),
      .REG_SLEEP_EN_O(slp), .UNLOCKED_O(unl));
   // Clock, 100 ns
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----
   // Tasks
   // ----
   function automatic logic [31:0] cmap(input logic [6:0] v);
      cmap = {2'b00, v[6], 19'h0, v[5], 1'b0, v[4], 2'b00, v[3], v[1], v[0], v[2], 1'b0};
   endfunction
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", s, x, g);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // One APB transfer, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         complete_run();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
      apb(1'b0, a, 32'h0);
      chk(s, x, q);
   endtask
   task automatic unlock;
      apb(1'b1, 8'h08, `RCS_KEY1);
      apb(1'b1, 8'h08, `RCS_KEY2);
      chk("unlocked", 32'h1, {31'h0, unl});
   endtask
   // Main sequence
   initial begin
      {rst_n, ce, psel, pen, pwr, paddr, pwdata, ev} = {2'b01, 3'b000, 8'h00, 32'h0, 7'h00};
      err_count = 0;
      checked = 0;
      void'($urandom(51));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(8'h00, 32'h3, "cause");
      chk("sleep", 32'h0, {31'h0, slp});
      rd(8'h04, 32'h0, "trigger");
      rd(8'h14, 32'h0, "lockstat");
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      rd(8'h00, `RCS_CAUSE_IMPL, "cause");
      chk("sleep", 32'h1, {31'h0, slp});
      ce <= 1'b0;
      apb(1'b1, 8'h00, 32'h0);
      ce <= 1'b1;
      rd(8'h00, `RCS_CAUSE_IMPL, "cause");
      apb(1'b1, 8'h00, 32'h0);
      rd(8'h00, 32'h0, "cause");
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      $display("register test done");
      for (int i = 0; i < 5; i++) begin
         p = (i == 0) ? 7'h7F : 7'($urandom);
         m = $urandom;
         apb(1'b1, 8'h10, m);
         ev <= p;
         repeat (6) @(posedge clk);
         ev <= 7'h00;
         rd(8'h00, cmap(p), "cause");
         rd(8'h0C, cmap(p), "status");
         chk("irq", {31'h0, |(cmap(p) & m)}, {31'h0, irq});
         apb(1'b1, 8'h00, 32'h0);
         apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
         chk("irq", 32'h0, {31'h0, irq});
      end
      $display("event test done");
      apb(1'b1, 8'h04, 32'h1);
      chk("soft", 32'h0, {31'h0, srst});
      unlock();
      rd(8'h14, 32'h1, "lockstat");
      apb(1'b1, 8'h04, 32'h0);
      chk("soft", 32'h0, {31'h0, srst});
      chk("unlocked", 32'h0, {31'h0, unl});
      unlock();
      apb(1'b1, 8'h04, 32'h1);
      chk("unlocked", 32'h0, {31'h0, unl});
      n = 0;
      while (srst === 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk("pulse", 32'd16, n);
      rd(8'h00, 32'h40, "cause");
      rd(8'h04, 32'h0, "trigger");
      rd(8'h40, 32'h0, "unmapped");
      chk("error", 32'h1, {31'h0, e});
      $display("soft reset test done");
      complete_run();
   end
endmodule
